// *** inc/btsk_pkg.sv ***
/*
 Constants for the bit-test-and-skip decode and execute block.
 Assumes a 16-bit instruction word and an 8-bit banked data memory.
*/
package btsk_pkg;
    // Opcode field and its two values
    localparam int            OPC_MSB      = 15;
    localparam int            OPC_LSB      = 12;
    localparam logic [3:0]    OPC_SKIP_CLR = 4'hB;
    localparam logic [3:0]    OPC_SKIP_SET = 4'hA;
    // Operand fields
    localparam int            BIT_MSB      = 11;
    localparam int            BIT_LSB      = 9;
    localparam int            ACC_POS      = 8;
    localparam int            FADR_MSB     = 7;
    localparam int            FADR_LSB     = 0;
    // Indexed literal offset window limit (inclusive)
    localparam logic [7:0]    IDX_LIMIT    = 8'h5F;
    // Access bank high part: all of bank 0
    localparam logic [3:0]    ACC_BANK     = 4'h0;
    // Reset values
    localparam logic [11:0]   ADDR_RST     = 12'h000;
    localparam logic [7:0]    IDX_RST      = 8'h00;
    localparam logic [2:0]    SEL_RST      = 3'h0;
endpackage

// *** sim/bit_test_skip_execute_tb.sv ***
/* Self-checking bench for the bit-test block.
 Memory model on the read port; checker bound. */
`timescale 1ns/1ps
module bit_test_skip_execute_tb;
    logic        sys_clk = 1'h0, nrst = 1'h0, instr_valid = 1'h0, ext_set_en = 1'h0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0]  bank_select_register = 4'h2;
    logic [11:0] index_base = 12'h000, rd_addr;
    logic [7:0]  rd_data;
    logic        rd_en, busy, skip_flush, nop_exec, done;
    int          failures = 0, checks_done = 0;
    localparam logic [3:0] SS = btsk_pkg::OPC_SKIP_SET;
    localparam logic [3:0] SC = btsk_pkg::OPC_SKIP_CLR;
    // Clock, 4 ns period
    initial forever #2 sys_clk = ~sys_clk;
    btsk_mem i_mem (.rd_addr, .rd_data);
    btsk_core i_dut (.sys_clk, .nrst, .instr_valid, .instr_word, .ext_set_en, .bank_select_register,
        .index_base, .rd_data, .rd_en, .rd_addr, .busy, .skip_flush, .nop_exec, .done);
    task automatic chk(input logic [11:0] a, input logic [11:0] e);
        checks_done++;
        if (a !== e)
        begin
            failures++;
            $display("ERROR %0t got %h want %h", $time, a, e);
        end
    endtask
    // One test instruction, address and skip judged
    task automatic run(input logic [15:0] w, input logic [11:0] ea);
        logic [7:0] d;
        logic       sk;
        d = ea[7:0] ^ {2{ea[11:8]}};
        sk = d[w[11:9]] == (w[15:12] == SS);
        @(negedge sys_clk);
        instr_valid = 1'h1;
        instr_word = w;
        @(negedge sys_clk);
        instr_valid = 1'h0;
        chk({rd_en, rd_addr}, {1'h1, ea});
        @(negedge sys_clk);
        chk({skip_flush, done}, {sk, !sk});
        if (sk)
        begin
            @(negedge sys_clk);
            chk({nop_exec, done, busy}, 3'h6);
        end
    endtask
    task automatic t_ops;
        for (int b = 0; b < 8; b++)
        begin
            run({SS, 3'(b), 1'h1, 8'h33}, 12'h233);
            run({SC, 3'(b), 1'h1, 8'h33}, 12'h233);
        end
    endtask
    task automatic t_acc;
        bank_select_register = 4'h7;
        run({SS, 3'h0, 1'h0, 8'h40}, 12'h040);
        ext_set_en = 1'h1;
        run({SC, 3'h7, 1'h0, 8'h60}, 12'h060);
    endtask
    task automatic t_idx;
        index_base = 12'h3F0;
        run({SS, 3'h1, 1'h0, 8'h5F}, 12'h44F);
        run({SC, 3'h4, 1'h0, 8'h00}, 12'h3F0);
        run({SS, 3'h0, 1'h1, 8'h10}, 12'h710);
    endtask
    // Word offered while busy must not start a second read
    task automatic t_busy;
        @(negedge sys_clk);
        instr_valid = 1'h1;
        instr_word = {SS, 3'h0, 1'h1, 8'h10};
        @(negedge sys_clk);
        instr_word = {SC, 3'h0, 1'h1, 8'h22};
        @(negedge sys_clk);
        instr_valid = 1'h0;
        chk({rd_en, rd_addr}, {1'h0, 12'h710});
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic t_ign;
        @(negedge sys_clk);
        instr_valid = 1'h1;
        instr_word = 16'h8123;
        @(negedge sys_clk);
        instr_valid = 1'h0;
        chk({rd_en, busy}, 2'h0);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset, then scenarios
    initial
    begin
        repeat (8) @(negedge sys_clk);
        nrst = 1'h1;
        repeat (3) @(negedge sys_clk);
        t_ops;
        t_acc;
        t_idx;
        t_busy;
        t_ign;
        conclude;
    end
    // Watchdog
    initial
    begin
        #20000;
        failures++;
        conclude;
    end
endmodule

// *** sim/btsk_checker.sv ***
/* Assertions on the bit-test block ports.
 Bound to btsk_core; words offered while busy are not decoded. */
`timescale 1ns/1ps
module btsk_checker (
    input wire logic        sys_clk,              // Core clock
    input wire logic        nrst,                 // Reset, active low
    input wire logic        instr_valid,          // Word offered
    input wire logic        ext_set_en,           // Extended set on
    input wire logic [15:0] instr_word,           // Word
    input wire logic [3:0]  bank_select_register, // Bank
    input wire logic [11:0] index_base,           // Index base
    input wire logic [11:0] rd_addr,              // Read address
    input wire logic [7:0]  rd_data,              // Read data
    input wire logic        rd_en,                // Read strobe
    input wire logic        busy,                 // Busy
    input wire logic        skip_flush,           // Flush pulse
    input wire logic        nop_exec,             // Nop pulse
    input wire logic        done                  // Done pulse
);
    localparam logic [3:0] SS = btsk_pkg::OPC_SKIP_SET;
    localparam logic [3:0] SC = btsk_pkg::OPC_SKIP_CLR;
    // Decode view of the offered word
    wire [3:0] op = instr_word[15:12];
    wire [7:0] f  = instr_word[7:0];
    wire tk  = instr_valid && !busy && (op == SS || op == SC);
    wire idx = !instr_word[8] && ext_set_en && f <= btsk_pkg::IDX_LIMIT;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_read; tk |=> rd_en && busy; endproperty
    a_read: assert property (p_read) else $error("no read after decode");
    property p_ign; instr_valid && !busy && op != SS && op != SC |=> !rd_en; endproperty
    a_ign: assert property (p_ign) else $error("other opcode read");
    property p_bank; tk && instr_word[8] |=> rd_addr == {$past(bank_select_register), $past(f)}; endproperty
    a_bank: assert property (p_bank) else $error("bank address wrong");
    property p_acc; tk && !instr_word[8] && !idx |=> rd_addr == {btsk_pkg::ACC_BANK, $past(f)}; endproperty
    a_acc: assert property (p_acc) else $error("access address wrong");
    property p_idx; tk && idx |=> rd_addr == $past(index_base) + {4'h0, $past(f)}; endproperty
    a_idx: assert property (p_idx) else $error("indexed address wrong");
    property p_set; rd_en && $past(op) == SS && rd_data[$past(instr_word[11:9])] |=> skip_flush; endproperty
    a_set: assert property (p_set) else $error("set skip missing");
    property p_clr; rd_en && $past(op) == SC && !rd_data[$past(instr_word[11:9])] |=> skip_flush; endproperty
    a_clr: assert property (p_clr) else $error("clear skip missing");
    // No skip: finish the cycle after the test, no flush
    property p_keep;
        rd_en && (rd_data[$past(instr_word[11:9])] != ($past(op) == SS)) |=> done && !skip_flush && !busy;
    endproperty
    a_keep: assert property (p_keep) else $error("skip without cause");
    property p_nop; skip_flush |-> busy && !done ##1 nop_exec && done && !busy; endproperty
    a_nop: assert property (p_nop) else $error("no nop after flush");
    c_skip: cover property (nop_exec);
    c_idx: cover property (tk && idx);
    c_bank: cover property (tk && instr_word[8]);
    c_refuse: cover property (instr_valid && busy);
endmodule
bind btsk_core btsk_checker i_chk (.sys_clk, .nrst, .instr_valid, .ext_set_en, .instr_word,
    .bank_select_register, .index_base, .rd_addr, .rd_data, .rd_en, .busy, .skip_flush, .nop_exec, .done);

// *** sim/btsk_mem.sv ***
/* Data memory model for the bit-test block.
 Combinational read of rd_addr, fixed pattern. */
`timescale 1ns/1ps
module btsk_mem (
    input  wire logic [11:0] rd_addr, // Read address
    output logic      [7:0]  rd_data  // Read data
);
    // Pattern mixes bank and offset so a wrong bank shows
    assign rd_data = rd_addr[7:0] ^ {2{rd_addr[11:8]}};
endmodule

// *** src/btsk_core.sv ***
/*
 Decode and execute of the two bit-test-and-skip instructions.
 Assumes a fetch pipeline that presents one instruction per cycle with
 instr_valid, and a data memory that answers a read in the same cycle as rd_en.
*/
`timescale 1ns/1ps

// What this block does
// - The set variant skips the next instruction when the tested bit reads one.
// - On a skip the prefetched instruction is dropped and a no-operation runs, taking two cycles.
// - With access bit zero the operand comes from the access bank, not the bank select register.
// - With access bit one the bank select register picks the general purpose register bank.
// - With access bit zero, extended set on and address at most 95, indexed literal offset is used.
// - The clear variant skips the next instruction when the tested bit reads zero.
// - Operands are an 8-bit file address, a 3-bit bit position and one access bit.
module btsk_core (
    input  wire logic        sys_clk,        // Core clock, 250 MHz
    input  wire logic        nrst,           // Async reset, active low
    input  wire logic        instr_valid,    // Instruction word present
    input  wire logic [15:0] instr_word,     // Instruction word
    input  wire logic        ext_set_en,     // Extended instruction set on
    input  wire logic [3:0]  bank_select_register, // Current bank
    input  wire logic [11:0] index_base,     // Index register for offset mode
    input  wire logic [7:0]  rd_data,        // Data memory read data
    output logic             rd_en,          // Data memory read strobe
    output logic [11:0]      rd_addr,        // Data memory read address
    output logic             busy,           // Test in progress, hold fetch
    output logic             skip_flush,     // Drop prefetched instruction
    output logic             nop_exec,       // No-operation runs this cycle
    output logic             done            // Test instruction finished
);

    // Controller states: idle, bit test, no-operation slot
    typedef enum logic [1:0] {ST_IDLE, ST_TEST, ST_NOP} btsk_state_e;

    // Reset release pair
    logic          rst_s1_q;
    logic          rst_n_q;
    // Control group: state, busy and one-cycle strobes
    // Busy is high exactly while the state is not idle, so fetch can hold on it
    btsk_state_e   state_q, state_d;
    logic          rd_en_q, rd_en_d;
    logic          busy_q, busy_d;
    logic          flush_q, flush_d;
    logic          nop_q, nop_d;
    logic          done_q, done_d;
    // Operand group, captured when a test is taken
    logic          want_set_q, want_set_d;
    logic [2:0]    sel_q, sel_d;
    logic [11:0]   addr_q, addr_d;
    // Fields of the offered word
    logic [3:0]    opc;
    logic [2:0]    bitpos;
    logic [7:0]    fadr;
    logic          acc;
    logic          is_test;
    // Operand address candidates
    logic          idx_mode;
    logic [11:0]   idx_addr;
    logic [11:0]   acc_addr;
    logic [11:0]   bank_addr;
    logic [11:0]   eff_addr;
    // Bit test result
    logic          bit_val;
    logic          skip_now;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_q <= 1'h0;
            rst_n_q  <= 1'h0;
        end
        else
        begin
            rst_s1_q <= 1'h1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Field split of the instruction word
    assign opc     = instr_word[btsk_pkg::OPC_MSB:btsk_pkg::OPC_LSB];
    assign bitpos  = instr_word[btsk_pkg::BIT_MSB:btsk_pkg::BIT_LSB];
    assign fadr    = instr_word[btsk_pkg::FADR_MSB:btsk_pkg::FADR_LSB];
    assign acc     = instr_word[btsk_pkg::ACC_POS];

    // Only the two test opcodes start work
    assign is_test = instr_valid && (opc == btsk_pkg::OPC_SKIP_CLR || opc == btsk_pkg::OPC_SKIP_SET);

    // Indexed mode covers the low window of the access bank only
    assign idx_mode  = !acc && ext_set_en && (fadr <= btsk_pkg::IDX_LIMIT);
    // Base plus offset wraps at 12 bits
    assign idx_addr  = 12'(index_base + {4'h0, fadr});
    // Access bank ignores the bank select register
    assign acc_addr  = {btsk_pkg::ACC_BANK, fadr};
    // Banked access through the bank select register
    assign bank_addr = {bank_select_register, fadr};
    // Indexed first, then banked, then access bank
    // Mode is fixed by the word as offered, not by a later bank change
    assign eff_addr  = idx_mode ? idx_addr : (acc ? bank_addr : acc_addr);

    // Memory answers in the test state; pick the captured bit
    // Hazard: rd_data must be settled in the same cycle as rd_en
    assign bit_val  = rd_data[sel_q];
    // Set variant skips on one, clear variant on zero
    assign skip_now = (bit_val == want_set_q);

    // Operand capture: only a taken test loads new operands
    always_comb
    begin
        want_set_d = want_set_q;
        sel_d      = sel_q;
        addr_d     = addr_q;
        if (is_test && state_q == ST_IDLE)
        begin
            want_set_d = (opc == btsk_pkg::OPC_SKIP_SET);
            sel_d      = bitpos;
            addr_d     = eff_addr;
        end
    end

    // Operand registers; rd_addr holds until the next taken test
    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            want_set_q <= 1'h0;
            sel_q      <= btsk_pkg::SEL_RST;
            addr_q     <= btsk_pkg::ADDR_RST;
        end
        else
        begin
            want_set_q <= want_set_d;
            sel_q      <= sel_d;
            addr_q     <= addr_d;
        end
    end

    // Sequencer: read, test, then an optional no-operation slot
    always_comb
    begin
        state_d = state_q;
        rd_en_d = 1'h0;
        busy_d  = 1'h0;
        flush_d = 1'h0;
        nop_d   = 1'h0;
        done_d  = 1'h0;
        unique case (state_q)
            ST_IDLE:
            begin
                // Words offered while busy are never looked at
                if (is_test)
                begin
                    rd_en_d = 1'h1;
                    busy_d  = 1'h1;
                    state_d = ST_TEST;
                end
            end
            ST_TEST:
            begin
                if (skip_now)
                begin
                    // Prefetched word dropped, fetch stays held
                    flush_d = 1'h1;
                    busy_d  = 1'h1;
                    state_d = ST_NOP;
                end
                else
                begin
                    // No skip: finish now
                    done_d  = 1'h1;
                    state_d = ST_IDLE;
                end
            end
            ST_NOP:
            begin
                // Slot of the dropped word
                nop_d   = 1'h1;
                done_d  = 1'h1;
                state_d = ST_IDLE;
            end
            default:
            begin
                // Unused code: back to idle without strobes
                state_d = ST_IDLE;
            end
        endcase
    end

    // Control registers
    always_ff @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_IDLE;
            rd_en_q <= 1'h0;
            busy_q  <= 1'h0;
            flush_q <= 1'h0;
            nop_q   <= 1'h0;
            done_q  <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            rd_en_q <= rd_en_d;
            busy_q  <= busy_d;
            flush_q <= flush_d;
            nop_q   <= nop_d;
            done_q  <= done_d;
        end
    end

    // Outputs straight from the registers
    assign rd_en      = rd_en_q;
    assign rd_addr    = addr_q;
    assign busy       = busy_q;
    assign skip_flush = flush_q;
    assign nop_exec   = nop_q;
    assign done       = done_q;

endmodule
